// file: rtl/asu_arith_unit.sv
// add/subtract arithmetic unit: sequencer, adder and accumulator halves
`timescale 1ns/1ps
`default_nettype none
module asu_arith_unit import asu_pkg::*; (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // instruction issue
    input wire logic start_i,
    input wire logic [CODE_W-1:0] func_code_i,
    input wire logic [CODE_W-1:0] sub_code_i,
    input wire logic [ADDR_W-1:0] y_addr_i,
    input wire logic [ADDR_W-1:0] index_b_i,
    // accumulator preload and flag clear
    input wire logic acc_wr_low_i,
    input wire logic acc_wr_high_i,
    input wire logic [WORD_W-1:0] acc_wr_data_i,
    input wire logic ovf_clear_i,
    // memory
    input wire logic [WORD_W-1:0] mem_data_i,
    output logic mem_start_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    // status and results
    output logic busy_o,
    output logic done_o,
    output logic reject_o,
    output logic [WORD_W-1:0] acc_low_half_o,
    output logic [WORD_W-1:0] acc_high_half_o,
    output logic overflow_o,
    output logic borrow_test_o
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_single(input logic [CODE_W-1:0] f);
        is_single = (f == FC_ADD_SINGLE) || (f == FC_ADD_SINGLE_IDX) ||
                    (f == FC_SUB_SINGLE) || (f == FC_SUB_SINGLE_IDX);
    endfunction

    function automatic logic is_sub(input logic [CODE_W-1:0] f);
        is_sub = (f == FC_SUB_SINGLE) || (f == FC_SUB_SINGLE_IDX);
    endfunction

    function automatic logic is_double(input logic [CODE_W-1:0] f);
        is_double = (f == FC_ADD_DOUBLE) || (f == FC_ADD_DOUBLE_IDX);
    endfunction

    function automatic logic is_indexed(input logic [CODE_W-1:0] f);
        is_indexed = (f == FC_ADD_SINGLE_IDX) || (f == FC_SUB_SINGLE_IDX) ||
                     (f == FC_ADD_DOUBLE_IDX);
    endfunction

    // bit WORD_W of the result is the borrow out
    function automatic logic [WORD_W:0] sub_word(input logic [WORD_W-1:0] a,
                                                 input logic [WORD_W-1:0] b,
                                                 input logic bin);
        sub_word = {1'b0, a} - {1'b0, b} - {{WORD_W{1'b0}}, bin};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    asu_state_t state_reg, state_next;
    logic [PH_W-1:0] phase_reg;
    logic [CODE_W-1:0] func_reg;
    logic [ADDR_W-1:0] y_reg;
    logic [ADDR_W-1:0] b_reg;
    logic [ADDR_W-1:0] operand_address_reg;
    logic [WORD_W-1:0] memory_word_buffer_reg;
    logic [WORD_W-1:0] x_reg;
    logic [WORD_W-1:0] d_reg;
    logic [WORD_W-1:0] acc_low_half_reg;
    logic [WORD_W-1:0] acc_high_half_reg;
    logic overflow_reg;
    logic borrow_test_reg;
    logic mem_start_reg;
    logic busy_reg;
    logic done_reg;
    logic reject_reg;

    // ------------------------------------------------------------
    // phase decode
    // ------------------------------------------------------------
    logic idle, run, take, supported, round_req;
    logic at_t11, at_t13, at_t14, at_t21, at_t23, at_t24;
    logic at_t32, at_t41, at_t42, at_t43, at_t44;
    logic high_side, low_side;
    assign idle = (state_reg == ST_IDLE);
    assign run = ce_i && !idle;
    assign round_req = (func_code_i == FC_ROUND) && (sub_code_i == SC_ROUND);
    assign supported = is_single(func_code_i) || is_double(func_code_i) || round_req;
    assign take = ce_i && idle && start_i;
    assign at_t11 = run && (phase_reg == PH_T11);
    assign at_t13 = run && (phase_reg == PH_T13);
    assign at_t14 = run && (phase_reg == PH_T14);
    assign at_t21 = run && (phase_reg == PH_T21);
    assign at_t23 = run && (phase_reg == PH_T23);
    assign at_t24 = run && (phase_reg == PH_T24);
    assign at_t32 = run && (phase_reg == PH_T32);
    assign at_t41 = run && (phase_reg == PH_T41);
    assign at_t42 = run && (phase_reg == PH_T42);
    assign at_t43 = run && (phase_reg == PH_T43);
    assign at_t44 = run && (phase_reg == PH_T44);
    assign high_side = (state_reg == ST_HIGH) || (state_reg == ST_ROUND);
    assign low_side = (state_reg == ST_SINGLE) || (state_reg == ST_LOW);

    // ------------------------------------------------------------
    // adder: X minus complement of D, end-around borrow by mode
    // ------------------------------------------------------------
    logic [WORD_W-1:0] d_comp, sum_word, acc_sel, d_sel;
    logic [WORD_W:0] raw, raw_lo;
    logic pass_bin, end_around_borrow, bin17, ovf_hit, wrap_here;
    logic [ADDR_W-1:0] addr_calc, addr_next;
    assign d_comp = ~d_reg;
    // the high pass takes the borrow that the low pass left behind
    assign pass_bin = (state_reg == ST_HIGH) && borrow_test_reg;
    assign raw = sub_word(x_reg, d_comp, pass_bin);
    assign raw_lo = sub_word({1'b0, x_reg[WORD_W-2:0]}, {1'b0, d_comp[WORD_W-2:0]}, pass_bin);
    assign end_around_borrow = raw[WORD_W];
    assign bin17 = raw_lo[WORD_W];
    assign ovf_hit = (!x_reg[WORD_W-1] && d_comp[WORD_W-1] && !bin17) ||
                     (x_reg[WORD_W-1] && !d_comp[WORD_W-1] && bin17);
    // single-word passes close the borrow on themselves; double passes forward it
    assign wrap_here = end_around_borrow &&
                       ((state_reg == ST_SINGLE) || (state_reg == ST_ROUND));
    assign sum_word = wrap_here ? raw[WORD_W-1:0] - WORD_ONE : raw[WORD_W-1:0];
    assign acc_sel = high_side ? acc_high_half_reg : acc_low_half_reg;
    assign d_sel = (state_reg == ST_ROUND) ? {{(WORD_W-1){1'b0}}, acc_low_half_reg[WORD_W-1]} :
                   is_sub(func_reg) ? ~memory_word_buffer_reg : memory_word_buffer_reg;
    assign addr_calc = y_reg + (is_indexed(func_reg) ? b_reg : '0);
    // even Y from software makes this the odd partner word
    assign addr_next = (state_reg == ST_HIGH) ? operand_address_reg + ADDR_STEP : addr_calc;

    // ------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && is_single(func_code_i)) begin
                    state_next = ST_SINGLE;
                end else if (take && is_double(func_code_i)) begin
                    state_next = ST_LOW;
                end else if (take && round_req) begin
                    state_next = ST_ROUND;
                end
            end
            ST_LOW: begin
                if (at_t43) begin
                    state_next = ST_HIGH;
                end
            end
            default: begin
                if (at_t43) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            phase_reg <= PH_T44;
        end else if (ce_i) begin
            state_reg <= state_next;
            phase_reg <= take ? PH_T44 : (idle ? phase_reg : phase_reg + PH_STEP);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            func_reg <= '0;
            y_reg <= '0;
            b_reg <= '0;
        end else if (take) begin
            func_reg <= func_code_i;
            y_reg <= y_addr_i;
            b_reg <= index_b_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            reject_reg <= 1'b0;
            mem_start_reg <= 1'b0;
        end else if (ce_i) begin
            busy_reg <= (state_next != ST_IDLE);
            done_reg <= at_t43 && (state_reg != ST_LOW);
            reject_reg <= take && !supported;
            mem_start_reg <= at_t11 && (state_reg != ST_ROUND);
        end
    end

    // ------------------------------------------------------------
    // operand path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operand_address_reg <= '0;
        end else if (at_t44 && (state_reg != ST_HIGH)) begin
            operand_address_reg <= '0;
        end else if (at_t11) begin
            operand_address_reg <= addr_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            memory_word_buffer_reg <= '0;
            x_reg <= '0;
        end else if (at_t13) begin
            memory_word_buffer_reg <= '0;
            x_reg <= '0;
        end else if (at_t14) begin
            x_reg <= acc_sel;
        end else if (at_t21) begin
            memory_word_buffer_reg <= mem_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d_reg <= '0;
        end else if (at_t23) begin
            d_reg <= '0;
        end else if (at_t24) begin
            d_reg <= d_sel;
        end
    end

    // ------------------------------------------------------------
    // accumulator halves and flags
    // ------------------------------------------------------------
    logic ovf_set, ovf_next;
    assign ovf_set = at_t32 && ovf_hit &&
                     ((state_reg == ST_SINGLE) || (state_reg == ST_HIGH));
    assign ovf_next = ovf_set || (overflow_reg && !ovf_clear_i);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_low_half_reg <= '0;
        end else if (ce_i && idle && acc_wr_low_i) begin
            acc_low_half_reg <= acc_wr_data_i;
        end else if (at_t41 && low_side) begin
            acc_low_half_reg <= '0;
        end else if (at_t42 && low_side) begin
            acc_low_half_reg <= sum_word;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_high_half_reg <= '0;
        end else if (ce_i && idle && acc_wr_high_i) begin
            acc_high_half_reg <= acc_wr_data_i;
        end else if (at_t41 && high_side) begin
            acc_high_half_reg <= '0;
        end else if (at_t42 && high_side) begin
            acc_high_half_reg <= sum_word;
        end
    end

    // a set in the clearing cycle wins
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_reg <= 1'b0;
        end else if (ce_i) begin
            overflow_reg <= ovf_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            borrow_test_reg <= 1'b0;
        end else if (at_t41 && (state_reg == ST_LOW)) begin
            borrow_test_reg <= 1'b0; // high pass keeps it as borrow-in until T4.2
        end else if (at_t42 && ((state_reg == ST_LOW) || (state_reg == ST_HIGH))) begin
            borrow_test_reg <= end_around_borrow;
        end
    end

    assign mem_start_o = mem_start_reg;
    assign mem_addr_o = operand_address_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign reject_o = reject_reg;
    assign acc_low_half_o = acc_low_half_reg;
    assign acc_high_half_o = acc_high_half_reg;
    assign overflow_o = overflow_reg;
    assign borrow_test_o = borrow_test_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_phase_step: assert property (run |=> phase_reg == $past(phase_reg) + PH_STEP)
        else $error("phase counter did not advance");
    a_addr_clear: assert property (at_t44 && state_reg == ST_LOW ##1 ce_i |->
        operand_address_reg == '0) else $error("address not cleared at T4.4");
    a_high_addr: assert property (at_t11 && state_reg == ST_HIGH |=>
        operand_address_reg == $past(operand_address_reg) + ADDR_STEP)
        else $error("high pass address is not Y+1");
    a_index_addr: assert property (at_t11 && state_reg == ST_SINGLE |=>
        operand_address_reg == $past(addr_calc) && mem_start_o)
        else $error("operand address or memory start wrong");
    a_dreg_load: assert property (at_t24 && state_reg == ST_SINGLE |=>
        d_reg == (is_sub(func_reg) ? ~memory_word_buffer_reg : memory_word_buffer_reg))
        else $error("D register load wrong");
    a_ovf_set: assert property (ovf_set |=> overflow_o)
        else $error("overflow flag not set");
    a_ovf_quiet: assert property (run && state_reg == ST_LOW |=>
        overflow_o == $past(overflow_reg) || $past(ovf_clear_i))
        else $error("overflow changed during low pass");
    a_low_hold: assert property (run && low_side && phase_reg < PH_T41 |=>
        $stable(acc_low_half_reg)) else $error("low half changed early");
    a_borrow_fwd: assert property (at_t42 && state_reg == ST_LOW && end_around_borrow
        |=> borrow_test_o ##1 (1'b1) [*2] ##0 pass_bin || !ce_i || state_reg != ST_HIGH)
        else $error("low pass borrow not forwarded");
    a_double_auto: assert property (at_t43 && state_reg == ST_LOW |=>
        state_reg == ST_HIGH && busy_o && !done_o) else $error("high pass not started");
    a_round_nomem: assert property (state_reg == ST_ROUND |-> !mem_start_o)
        else $error("round made a memory reference");

    c_single: cover property (at_t43 && state_reg == ST_SINGLE);
    c_double: cover property (at_t43 && state_reg == ST_HIGH && pass_bin);
    c_round: cover property (at_t43 && state_reg == ST_ROUND);
    c_ovf: cover property (ovf_set);

endmodule // asu_arith_unit
`default_nettype wire

// file: shared/asu_pkg.sv
// constants and types for the add/subtract arithmetic unit
// Overview of operation
// - double add joins both halves as 36 bits
// - datapath works eighteen bits per pass
// - low half with Y, high half with Y+1
// - both passes run from one instruction
// - adder subtracts complement of memory operand
// - low pass borrow applied to high pass
// - codes 14,15 single add; 20,21 double add
// - code 50:60 is round, no memory
// - fixed command phases for the result sequence
// - D gets operand, complement for subtract codes
// - overflow flag set at T3.2
// - overflow from bit 17 borrow condition
// - single add returns sum to low half
// - single subtract returns difference to low half
// - indexed codes add index to address
// - low pass borrow recorded in borrow test
package asu_pkg;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 15;
    localparam int CODE_W = 6;
    localparam int PH_W = 4;
    localparam logic [CODE_W-1:0] FC_ADD_SINGLE = 6'h0c;
    localparam logic [CODE_W-1:0] FC_ADD_SINGLE_IDX = 6'h0d;
    localparam logic [CODE_W-1:0] FC_SUB_SINGLE = 6'h0e;
    localparam logic [CODE_W-1:0] FC_SUB_SINGLE_IDX = 6'h0f;
    localparam logic [CODE_W-1:0] FC_ADD_DOUBLE = 6'h10;
    localparam logic [CODE_W-1:0] FC_ADD_DOUBLE_IDX = 6'h11;
    localparam logic [CODE_W-1:0] FC_ROUND = 6'h28;
    localparam logic [CODE_W-1:0] SC_ROUND = 6'h30;
    localparam logic [PH_W-1:0] PH_T11 = 4'h0;
    localparam logic [PH_W-1:0] PH_T13 = 4'h2;
    localparam logic [PH_W-1:0] PH_T14 = 4'h3;
    localparam logic [PH_W-1:0] PH_T21 = 4'h4;
    localparam logic [PH_W-1:0] PH_T23 = 4'h6;
    localparam logic [PH_W-1:0] PH_T24 = 4'h7;
    localparam logic [PH_W-1:0] PH_T32 = 4'h9;
    localparam logic [PH_W-1:0] PH_T41 = 4'hc;
    localparam logic [PH_W-1:0] PH_T42 = 4'hd;
    localparam logic [PH_W-1:0] PH_T43 = 4'he;
    localparam logic [PH_W-1:0] PH_T44 = 4'hf;
    localparam logic [PH_W-1:0] PH_STEP = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
    localparam logic [WORD_W-1:0] WORD_ONE = 18'h00001;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SINGLE,
        ST_LOW,
        ST_HIGH,
        ST_ROUND
    } asu_state_t;
endpackage

// file: test/asu_mem_model.sv
// memory model answering the operand fetches of the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module asu_mem_model import asu_pkg::*; (
    // clock
    input wire logic clk_sys_i,
    // fetch request and answer
    input wire logic mem_start_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    output logic [WORD_W-1:0] mem_data_o
);
    logic [WORD_W-1:0] store [0:(1<<ADDR_W)-1];
    logic [WORD_W-1:0] word_reg;
    logic [2:0] age_reg;

    initial begin
        age_reg = 3'h0;
        word_reg = 18'h00000;
    end

    // the bench places the low half at the even address, the high half above it
    task automatic put(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        store[a] = d;
    endtask

    always @(posedge clk_sys_i) begin
        if (mem_start_i) begin
            word_reg <= store[mem_addr_i];
            age_reg <= 3'h1;
        end else if (age_reg != 3'h0 && age_reg != 3'h7) begin
            age_reg <= age_reg + 3'h1;
        end
    end

    // word valid only in its access window; outside it the bus shows the inverse,
    // so a late or early sample cannot pass by luck
    assign mem_data_o = (age_reg == 3'h3 || age_reg == 3'h4) ? word_reg : ~word_reg;
endmodule // asu_mem_model
`default_nettype wire

// file: test/add_subtract_arith_unit_tb.sv
// self-checking testbench of the add/subtract arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module add_subtract_arith_unit_tb import asu_pkg::*; ;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic start_i = 1'b0;
    logic acc_wr_low_i = 1'b0;
    logic acc_wr_high_i = 1'b0;
    logic ovf_clear_i = 1'b0;
    logic [CODE_W-1:0] func_code_i = 6'h00;
    logic [CODE_W-1:0] sub_code_i = 6'h00;
    logic [ADDR_W-1:0] y_addr_i = 15'h0000;
    logic [ADDR_W-1:0] index_b_i = 15'h0000;
    logic [WORD_W-1:0] acc_wr_data_i = 18'h00000;
    wire logic [WORD_W-1:0] mem_data_i;
    logic mem_start_o, busy_o, done_o, reject_o, overflow_o, borrow_test_o;
    logic [ADDR_W-1:0] mem_addr_o;
    logic [WORD_W-1:0] acc_low_half_o, acc_high_half_o;
    int fails = 0;
    int checked = 0;
    int dcnt, nst, rj;
    logic [ADDR_W-1:0] adr [2];
    logic [WORD_W-1:0] mid;

    always #5 clk_sys_i = ~clk_sys_i;

    asu_arith_unit i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .start_i(start_i), .func_code_i(func_code_i), .sub_code_i(sub_code_i),
        .y_addr_i(y_addr_i), .index_b_i(index_b_i), .acc_wr_low_i(acc_wr_low_i),
        .acc_wr_high_i(acc_wr_high_i), .acc_wr_data_i(acc_wr_data_i),
        .ovf_clear_i(ovf_clear_i), .mem_data_i(mem_data_i), .mem_start_o(mem_start_o),
        .mem_addr_o(mem_addr_o), .busy_o(busy_o), .done_o(done_o), .reject_o(reject_o),
        .acc_low_half_o(acc_low_half_o), .acc_high_half_o(acc_high_half_o),
        .overflow_o(overflow_o), .borrow_test_o(borrow_test_o));

    asu_mem_model i_mem (.clk_sys_i(clk_sys_i), .mem_start_i(mem_start_o),
        .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // x minus the complement of d, with the bit-17 overflow condition
    task automatic sub_model(input logic [17:0] x, input logic [17:0] d, input logic bin,
                             output logic [17:0] r, output logic bo, output logic ov);
        logic [18:0] full;
        logic [17:0] lo;
        full = {1'b0, x} - {1'b0, ~d} - 19'(bin);
        lo = {1'b0, x[16:0]} - {1'b0, ~d[16:0]} - 18'(bin);
        r = full[17:0];
        bo = full[18];
        ov = (~x[17] & ~d[17] & ~lo[17]) | (x[17] & d[17] & lo[17]);
    endtask

    task automatic preload(input logic [17:0] lo, input logic [17:0] hi);
        @(negedge clk_sys_i);
        acc_wr_low_i = 1'b1;
        acc_wr_data_i = lo;
        @(negedge clk_sys_i);
        acc_wr_low_i = 1'b0;
        acc_wr_high_i = 1'b1;
        acc_wr_data_i = hi;
        @(negedge clk_sys_i);
        acc_wr_high_i = 1'b0;
        ovf_clear_i = 1'b1;
        @(negedge clk_sys_i);
        ovf_clear_i = 1'b0;
    endtask

    // issue one instruction; a stray start is raised while busy, and ce_i drops
    // for gap cycles after the operand fetch
    task automatic run(input logic [5:0] fc, input logic [5:0] sc, input logic [14:0] y,
                       input logic [14:0] b, input int gap);
        dcnt = 0;
        nst = 0;
        rj = 0;
        @(negedge clk_sys_i);
        start_i = 1'b1;
        func_code_i = fc;
        sub_code_i = sc;
        y_addr_i = y;
        index_b_i = b;
        for (int c = 1; c < 60 && dcnt == 0; c++) begin
            @(negedge clk_sys_i);
            if (mem_start_o === 1'b1 && nst < 2) begin
                adr[nst] = mem_addr_o;
                nst++;
            end
            if (c == 10) mid = acc_low_half_o;
            if (reject_o === 1'b1) rj = c;
            if (done_o === 1'b1 || reject_o === 1'b1) dcnt = c;
            start_i = (c == 3 && busy_o === 1'b1);
            ce_i = !(c >= 11 && c < 11 + gap);
        end
        @(negedge clk_sys_i);
        chk(36'({busy_o, done_o}), 36'h0, "idle after end");
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_single();
        logic [5:0] fc [4] = '{FC_ADD_SINGLE, FC_ADD_SINGLE_IDX, FC_SUB_SINGLE, FC_SUB_SINGLE_IDX};
        logic [17:0] acc [4] = '{18'h1ffff, 18'h00005, 18'h00005, 18'h20003};
        logic [17:0] wd [4] = '{18'h00001, 18'h00003, 18'h00003, 18'h1fff0};
        logic [14:0] a;
        logic [17:0] r;
        logic bo, ov;
        for (int i = 0; i < 4; i++) begin
            a = i[0] ? 15'h0061 : 15'h0040;
            i_mem.put(a, wd[i]);
            preload(acc[i], 18'h00000);
            run(fc[i], 6'h00, 15'h0040, 15'h0021, (i == 1) ? 3 : 0);
            sub_model(acc[i], (i >= 2) ? ~wd[i] : wd[i], 1'b0, r, bo, ov);
            if (bo) r = r - 18'h00001;
            chk(36'(dcnt), 36'(17 + ((i == 1) ? 3 : 0)), "single length");
            chk(36'(adr[0]), 36'(a), "operand address");
            chk(36'(mid), 36'(acc[i]), "low half held");
            chk(36'(acc_low_half_o), 36'(r), "single result");
            chk(36'(overflow_o), 36'(ov), "single overflow");
            chk(36'(acc_high_half_o), 36'h0, "high half untouched");
        end
        $display("test single done");
    endtask

    task automatic t_double();
        logic [5:0] fc [2] = '{FC_ADD_DOUBLE, FC_ADD_DOUBLE_IDX};
        logic [17:0] lo [2] = '{18'h000ca, 18'h3fff0};
        logic [17:0] hi [2] = '{18'h00131, 18'h00002};
        logic [17:0] w0 [2] = '{18'h00001, 18'h00020};
        logic [17:0] w1 [2] = '{18'h00000, 18'h3fffd};
        logic [14:0] a;
        logic [17:0] rl, rh;
        logic b1, b2, o1, o2;
        for (int i = 0; i < 2; i++) begin
            a = i[0] ? 15'h0a10 : 15'h0a00;
            i_mem.put(a, w0[i]);
            i_mem.put(a + 15'h0001, w1[i]);
            preload(lo[i], hi[i]);
            run(fc[i], 6'h00, 15'h0a00, 15'h0010, 0);
            sub_model(lo[i], w0[i], 1'b0, rl, b1, o1);
            sub_model(hi[i], w1[i], b1, rh, b2, o2);
            chk(36'(dcnt), 36'd33, "double length");
            chk(36'({nst[1:0], adr[0], adr[1]}), 36'({2'd2, a, a + 15'h0001}), "pass addr");
            chk(36'({acc_high_half_o, acc_low_half_o}), 36'({rh, rl}), "double sum");
            chk(36'({borrow_test_o, overflow_o}), 36'({b2, o2}), "double flags");
        end
        $display("test double done");
    endtask

    task automatic t_round();
        logic [17:0] r;
        logic bo, ov;
        preload(18'h20000, 18'h00007);
        run(FC_ROUND, SC_ROUND, 15'h0000, 15'h0000, 0);
        sub_model(18'h00007, 18'h00001, 1'b0, r, bo, ov);
        if (bo) r = r - 18'h00001;
        chk(36'({dcnt[7:0], nst[1:0]}), 36'({8'd17, 2'd0}), "round, no fetch");
        chk(36'({acc_high_half_o, acc_low_half_o}), 36'({r, 18'h20000}), "round value");
        $display("test round done");
    endtask

    task automatic t_reject();
        preload(18'h00011, 18'h00022);
        run(6'h12, 6'h00, 15'h0040, 15'h0000, 0);
        chk(36'({rj[7:0], nst[1:0]}), 36'({8'd1, 2'd0}), "unsupported code");
        chk(36'({acc_high_half_o, acc_low_half_o}), 36'h000880011, "acc kept");
        $display("test reject done");
    endtask

    // ------------------------------------------------------------------
    // sequence, watchdog, verdict
    // ------------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        chk(36'({acc_low_half_o, overflow_o, borrow_test_o, busy_o, done_o}), 36'h0, "reset");
        $display("test reset done");
        t_single();
        t_double();
        t_round();
        t_reject();
        results();
    end

    // whole run is well under a thousand cycles
    initial begin
        #(3000 * 10);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end
endmodule // add_subtract_arith_unit_tb
`default_nettype wire
